// [src/quadrature_counter.sv]
// Quadrature edge counter with APB register access
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Count always visible as signed value
// - Clear only in run mode, by clear
// - Retained count survives stop and supply loss
// - Start in run resumes from retained count
// - Count both edges: twice the pulses
// - At reset, null and lower flags set
// - Upward edges add one; flags follow the new count
// - Upper flag when count at/above upper
// - Lower flag when count at/below lower
// - Null flag exactly when count zero
// - Load pulse copies start value, flags follow
// - Direction coil inverts the count sense of edges
// - Clear forces zero, null flag follows
// - Range excursion sets flags by direction
// - All values signed 32-bit full range
// - Overflow flag marks range left
// - Count only while enabled
module quadrature_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chan_a,
  input  wire logic        chan_b,
  input  wire logic        run_mode,
  input  wire logic        retain_cfg,
  output logic      [31:0] count_out,
  output logic             null_flag,
  output logic             lower_hit_flag,
  output logic             upper_hit_flag,
  output logic             range_overflow_flag
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [qc_pkg::PIN_COUNT-1:0] pin_s;
  logic                         a_edge;
  logic [31:0]                  stored;
  logic [1:0]                   ctrl_q;
  logic [31:0]                  upper_q;
  logic [31:0]                  lower_q;
  logic [31:0]                  preset_q;
  logic [31:0]                  count_q;
  logic [31:0]                  count_d;
  logic                         ovf_pos_q;
  logic                         ovf_pos_d;
  logic                         ovf_neg_q;
  logic                         ovf_neg_d;
  qc_pkg::flags_t               flags_q;
  qc_pkg::flags_t               flags_d;
  qc_pkg::phase_t               phase_q;
  qc_pkg::phase_t               phase_d;
  logic [2:0]                   wait_q;
  logic [31:0]                  rdata_d;
  logic                         map_hit;

  // ************************************************************
  // Pin conditioning and retained store
  // ************************************************************
  pin_conditioner u_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins     ({retain_cfg, run_mode, chan_b, chan_a}),
    .stable_q (pin_s),
    .a_edge_q (a_edge)
  );

  wire run_s    = pin_s[qc_pkg::PIN_RUN];
  wire retain_s = pin_s[qc_pkg::PIN_RETAIN];

  // Writes stay off until start-up is done, else reset zeros the store
  wire store_we = retain_s && (phase_q == qc_pkg::ST_RUN);

  retain_store u_store (
    .pclk    (pclk),
    .we      (store_we),
    .wdata   (count_d),
    .rdata_q (stored)
  );

  // ************************************************************
  // APB decode
  // ************************************************************
  wire setup_ph   = psel && !penable;
  wire wr_fire    = psel && penable && pready && pwrite;
  wire wr_ctrl    = wr_fire && (paddr == qc_pkg::OFS_CTRL);
  wire wr_cmd     = wr_fire && (paddr == qc_pkg::OFS_CMD);
  wire wr_upper   = wr_fire && (paddr == qc_pkg::OFS_UPPER);
  wire wr_lower   = wr_fire && (paddr == qc_pkg::OFS_LOWER);
  wire wr_preset  = wr_fire && (paddr == qc_pkg::OFS_PRESET);
  wire load_fire  = wr_cmd && pwdata[qc_pkg::CMD_LOAD_BIT];
  wire clr_fire   = wr_cmd && pwdata[qc_pkg::CMD_CLEAR_BIT] && run_s;
  wire enable_on  = ctrl_q[qc_pkg::CTRL_ENABLE_BIT];
  wire dir_coil   = ctrl_q[qc_pkg::CTRL_DIR_BIT];
  wire [31:0] upper_d = wr_upper ? pwdata : upper_q;
  wire [31:0] lower_d = wr_lower ? pwdata : lower_q;

  assign map_hit = (paddr == qc_pkg::OFS_CTRL) || (paddr == qc_pkg::OFS_CMD)
                || (paddr == qc_pkg::OFS_UPPER) || (paddr == qc_pkg::OFS_LOWER)
                || (paddr == qc_pkg::OFS_PRESET) || (paddr == qc_pkg::OFS_COUNT)
                || (paddr == qc_pkg::OFS_STATUS);

  // Read mux; command register reads as zero
  always_comb begin
    rdata_d = 32'h00000000;
    case (paddr)
      qc_pkg::OFS_CTRL:   rdata_d = {30'h00000000, ctrl_q};
      qc_pkg::OFS_UPPER:  rdata_d = upper_q;
      qc_pkg::OFS_LOWER:  rdata_d = lower_q;
      qc_pkg::OFS_PRESET: rdata_d = preset_q;
      qc_pkg::OFS_COUNT:  rdata_d = count_q;
      qc_pkg::OFS_STATUS: rdata_d = {27'h0000000, run_s, flags_q};
      default:            rdata_d = 32'h00000000;
    endcase
  end

  // Zero-wait slave: answer is registered during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !map_hit;
      prdata  <= (setup_ph && !pwrite) ? rdata_d : 32'h00000000;
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= qc_pkg::CTRL_RESET;
      upper_q  <= qc_pkg::UPPER_RESET;
      lower_q  <= qc_pkg::LOWER_RESET;
      preset_q <= qc_pkg::PRESET_RESET;
    end else begin
      if (wr_ctrl)   ctrl_q   <= pwdata[1:0];
      if (wr_preset) preset_q <= pwdata;
      upper_q <= upper_d;
      lower_q <= lower_d;
    end
  end

  // ************************************************************
  // Start-up: wait for the synchronised straps, then restore
  // ************************************************************
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      qc_pkg::ST_WAIT:    if (wait_q == qc_pkg::RESTORE_WAIT) phase_d = qc_pkg::ST_RESTORE;
      qc_pkg::ST_RESTORE: phase_d = qc_pkg::ST_RUN;
      qc_pkg::ST_RUN:     phase_d = qc_pkg::ST_RUN;
      default:            phase_d = qc_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= qc_pkg::ST_WAIT;
      wait_q  <= 3'h0;
    end else begin
      phase_q <= phase_d;
      if (phase_q == qc_pkg::ST_WAIT) wait_q <= wait_q + 3'h1;
    end
  end

  // ************************************************************
  // Count path
  // ************************************************************
  // Natural sense from the channel phase, inverted by the direction coil
  wire nat_down = pin_s[qc_pkg::PIN_A] == pin_s[qc_pkg::PIN_B];
  wire step_dn  = nat_down ^ dir_coil;
  wire step_en  = a_edge && enable_on && run_s
               && (phase_q == qc_pkg::ST_RUN);
  wire at_max   = (count_q == qc_pkg::COUNT_MAX);
  wire at_min   = (count_q == qc_pkg::COUNT_MIN);
  wire restore  = (phase_q == qc_pkg::ST_RESTORE) && retain_s && run_s;

  // Priority: restore, clear, load, count; saturate at the range ends
  always_comb begin
    count_d   = count_q;
    ovf_pos_d = ovf_pos_q;
    ovf_neg_d = ovf_neg_q;
    if (restore) begin
      count_d = stored;
    end else if (clr_fire) begin
      count_d   = 32'h00000000;
      ovf_pos_d = 1'b0;
      ovf_neg_d = 1'b0;
    end else if (load_fire) begin
      count_d   = preset_q;
      ovf_pos_d = 1'b0;
      ovf_neg_d = 1'b0;
    end else if (step_en) begin
      if (step_dn) begin
        if (at_min) ovf_neg_d = 1'b1;
        else count_d = count_q - 32'h00000001;
      end else begin
        if (at_max) ovf_pos_d = 1'b1;
        else count_d = count_q + 32'h00000001;
      end
    end
  end

  // Flags follow the next count so they move in the same cycle
  assign flags_d.null_f = (count_d == 32'h00000000);
  assign flags_d.upper  = ($signed(count_d) >= $signed(upper_d)) || ovf_pos_d;
  assign flags_d.lower  = ($signed(count_d) <= $signed(lower_d)) || ovf_neg_d;
  assign flags_d.ovf    = ovf_pos_d || ovf_neg_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= 32'h00000000;
      ovf_pos_q <= 1'b0;
      ovf_neg_q <= 1'b0;
      // Zero count sits on the reset lower limit, so null and lower start set
      flags_q   <= qc_pkg::FLAGS_RESET;
    end else begin
      count_q   <= count_d;
      ovf_pos_q <= ovf_pos_d;
      ovf_neg_q <= ovf_neg_d;
      flags_q   <= flags_d;
    end
  end

  // Outputs straight from flip-flops
  assign count_out           = count_q;
  assign null_flag           = flags_q.null_f;
  assign lower_hit_flag      = flags_q.lower;
  assign upper_hit_flag      = flags_q.upper;
  assign range_overflow_flag = flags_q.ovf;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_null_tracks:
    assert property (null_flag == (count_out == 32'h00000000))
      else $error("null flag does not match count");
  chk_upper_tracks:
    assert property (!ovf_pos_q |-> upper_hit_flag == ($signed(count_out) >= $signed(upper_q)))
      else $error("upper flag does not match count");
  chk_lower_tracks:
    assert property (!ovf_neg_q |-> lower_hit_flag == ($signed(count_out) <= $signed(lower_q)))
      else $error("lower flag does not match count");
  chk_clear_zero:
    assert property (clr_fire && !restore |=> count_out == 32'h00000000 && null_flag)
      else $error("clear did not zero the count");
  chk_clear_stop:
    assert property (wr_cmd && pwdata[qc_pkg::CMD_CLEAR_BIT] && !run_s && !load_fire
                     && !restore |=> $stable(count_out))
      else $error("clear acted outside run mode");
  chk_load_start:
    assert property (load_fire && !clr_fire && !restore |=> count_out == $past(preset_q))
      else $error("load did not copy the start value");
  chk_step_up:
    assert property (step_en && !step_dn && !at_max && !clr_fire && !load_fire
                     |=> count_out == $past(count_out) + 32'h00000001)
      else $error("upward edge did not add one");
  chk_step_down:
    assert property (step_en && step_dn && !at_min && !clr_fire && !load_fire
                     |=> count_out == $past(count_out) - 32'h00000001)
      else $error("downward edge did not subtract one");
  chk_enable_hold:
    assert property (!enable_on && !clr_fire && !load_fire && !restore |=> $stable(count_out))
      else $error("count moved while disabled");
  chk_ovf_sticky:
    assert property (range_overflow_flag && !clr_fire && !load_fire |=> range_overflow_flag)
      else $error("overflow flag dropped on its own");
  chk_pos_excursion:
    assert property (step_en && !step_dn && at_max && !clr_fire && !load_fire && !restore
                     |=> range_overflow_flag && upper_hit_flag)
      else $error("positive excursion flags wrong");
  chk_neg_excursion:
    assert property (step_en && step_dn && at_min && !clr_fire && !load_fire && !restore
                     |=> range_overflow_flag && lower_hit_flag)
      else $error("negative excursion flags wrong");

endmodule
`default_nettype wire

// [src/qc_pkg.sv]
// Shared constants and types for the quadrature edge counter
package qc_pkg;

  // ************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_UPPER  = 8'h08;
  localparam logic [7:0] OFS_LOWER  = 8'h0C;
  localparam logic [7:0] OFS_PRESET = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DIR_BIT    = 1;
  localparam int CMD_LOAD_BIT    = 0;
  localparam int CMD_CLEAR_BIT   = 1;
  localparam int STAT_RUN_BIT    = 4;

  // Pin indices inside the synchroniser vector
  localparam int PIN_A      = 0;
  localparam int PIN_B      = 1;
  localparam int PIN_RUN    = 2;
  localparam int PIN_RETAIN = 3;
  localparam int PIN_COUNT  = 4;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [31:0] UPPER_RESET  = 32'h7FFFFFFF;
  localparam logic [31:0] LOWER_RESET  = 32'h00000000;
  localparam logic [31:0] PRESET_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_MAX    = 32'h7FFFFFFF;
  localparam logic [31:0] COUNT_MIN    = 32'h80000000;
  localparam logic [2:0]  RESTORE_WAIT = 3'h6;

  // Status flags as one carrier
  typedef struct packed {
    logic ovf;
    logic upper;
    logic lower;
    logic null_f;
  } flags_t;

  // Flags after reset match a zero count against the reset setpoints
  localparam flags_t      FLAGS_RESET  = 4'h3;

  // Start-up sequence of the counter
  typedef enum logic [2:0] {
    ST_WAIT    = 3'b001,
    ST_RESTORE = 3'b010,
    ST_RUN     = 3'b100
  } phase_t;

endpackage

// [src/pin_conditioner.sv]
// Three-stage pin synchronisers with agreement filter and A-edge pulse
`timescale 1ns/10ps
`default_nettype none
module pin_conditioner (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [qc_pkg::PIN_COUNT-1:0] pins,
  output logic      [qc_pkg::PIN_COUNT-1:0] stable_q,
  output logic                             a_edge_q
);

  logic [qc_pkg::PIN_COUNT-1:0] ff1_q;
  logic [qc_pkg::PIN_COUNT-1:0] ff2_q;
  logic [qc_pkg::PIN_COUNT-1:0] ff3_q;
  logic [qc_pkg::PIN_COUNT-1:0] stable_d;

  // ************************************************************
  // Per-pin synchroniser; a change counts once stages 2 and 3 agree
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < qc_pkg::PIN_COUNT; gi++) begin : g_sync
      assign stable_d[gi] = (ff2_q[gi] == ff3_q[gi]) ? ff3_q[gi] : stable_q[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ff1_q[gi]    <= 1'b0;
          ff2_q[gi]    <= 1'b0;
          ff3_q[gi]    <= 1'b0;
          stable_q[gi] <= 1'b0;
        end else begin
          ff1_q[gi]    <= pins[gi];
          ff2_q[gi]    <= ff1_q[gi];
          ff3_q[gi]    <= ff2_q[gi];
          stable_q[gi] <= stable_d[gi];
        end
      end
    end
  endgenerate

  // Both edges of channel A count, giving twice the pulse number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_edge_q <= 1'b0;
    end else begin
      a_edge_q <= stable_d[qc_pkg::PIN_A] ^ stable_q[qc_pkg::PIN_A];
    end
  end

endmodule
`default_nettype wire

// [src/retain_store.sv]
// Count store that keeps its content over stop and supply loss
`timescale 1ns/10ps
`default_nettype none
module retain_store (
  input  wire logic        pclk,
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata_q
);

  // No reset on purpose: the content must outlive a reset
  logic [31:0] mem_q;

  // ************************************************************
  // Write and registered read
  // ************************************************************
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_q <= wdata;
    end
    rdata_q <= mem_q;
  end

endmodule
`default_nettype wire

// [testbench/quad_encoder_model.sv]
// Behavioural incremental encoder that drives the two offset pulse channels
`timescale 1ns/10ps
`default_nettype none
module quad_encoder_model #(
  parameter int QTR = 4
) (
  input  wire logic pclk,
  output var  logic chan_a,
  output var  logic chan_b
);
  // ************************************************************
  // Channel pattern
  // ************************************************************
  // Both channels low at rest, so the first edge of a pulse is clean
  initial begin
    chan_a = 1'b0;
    chan_b = 1'b0;
  end

  // One full period, four equal quarters: equal mark and space, 90 degrees apart
  // Forward lets A lead B; reverse lets B lead, so the counter must count down
  task automatic pulse(input logic down);
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      if (i[0] ^ down) begin
        chan_b <= ~chan_b;
      end else begin
        chan_a <= ~chan_a;
      end
      repeat (QTR - 1) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the quadrature edge counter
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic               pclk, presetn, psel, penable, pwrite, run_mode, retain_cfg;
  logic               pready, pslverr, chan_a, chan_b, err, null_flag, lower_hit_flag;
  logic               upper_hit_flag, range_overflow_flag, e_en, e_dir, e_run, e_ovf, e_neg;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata, count_out, rd, seed;
  logic signed [31:0] e_cnt, e_lo, e_up, v;
  logic        [7:0]  ra [4] = '{8'h00, 8'h08, 8'h0C, 8'h10};
  int                 err_total, checks_done, k;

  // ************************************************************
  // Design and encoder
  // ************************************************************
  quadrature_counter u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_a(chan_a), .chan_b(chan_b), .run_mode(run_mode), .retain_cfg(retain_cfg),
    .count_out(count_out), .null_flag(null_flag), .lower_hit_flag(lower_hit_flag),
    .upper_hit_flag(upper_hit_flag), .range_overflow_flag(range_overflow_flag));
  quad_encoder_model #(.QTR(4)) u_enc (.pclk(pclk), .chan_a(chan_a), .chan_b(chan_b));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Repeatable xorshift stream
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Flags the count and setpoints call for; excursion overrides the compares
  function automatic logic [31:0] fexp();
    fexp = 32'h0;
    fexp[0] = (e_cnt == 0);
    fexp[1] = (e_cnt <= e_lo) || (e_ovf && e_neg);
    fexp[2] = (e_cnt >= e_up) || (e_ovf && !e_neg);
    fexp[3] = e_ovf;
  endfunction

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // APB master; pready and the answer are taken at the rising edge that samples them
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("Error at %0t: no ready", $time);
      tally_and_finish();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Encoder pulses; each gives two counted edges unless counting is off
  task automatic move(input int pulses, input logic down);
    repeat (pulses) begin
      u_enc.pulse(down);
      repeat (2) begin
        if (e_en && e_run) begin
          if (!(down ^ e_dir) && e_cnt == qc_pkg::COUNT_MAX) {e_ovf, e_neg} = 2'b10;
          else if ((down ^ e_dir) && e_cnt == qc_pkg::COUNT_MIN) {e_ovf, e_neg} = 2'b11;
          else e_cnt = (down ^ e_dir) ? e_cnt - 1 : e_cnt + 1;
        end
      end
    end
    repeat (8) @(posedge pclk);
  endtask

  // Output pins and the register view must both agree with the expectation
  task automatic check_state();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(count_out, e_cnt);
    chk({28'h0, range_overflow_flag, upper_hit_flag, lower_hit_flag, null_flag}, fexp());
    apb(1'b0, qc_pkg::OFS_COUNT, 32'h0);
    chk(rd, e_cnt);
    apb(1'b0, qc_pkg::OFS_STATUS, 32'h0);
    chk(rd, fexp() | {27'h0, e_run, 4'h0});
  endtask

  // Run pin passes a synchroniser, so allow it to settle
  task automatic set_run(input logic b);
    @(posedge pclk);
    run_mode <= b;
    repeat (8) @(posedge pclk);
    e_run = b;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (16) @(posedge pclk);
    {e_en, e_dir, e_ovf} = 3'h0;
    e_lo = qc_pkg::LOWER_RESET;
    e_up = qc_pkg::UPPER_RESET;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, retain_cfg} = 5'h0;
    {paddr, pwdata} = 40'h0;
    run_mode = 1'b1;
    seed = 32'h0000E8EA;
    {err_total, checks_done} = 0;
    {e_cnt, e_run, e_neg} = {32'h0, 2'b10};
    do_reset();
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, (i == 1) ? qc_pkg::UPPER_RESET : 32'h0);
    end
    apb(1'b1, qc_pkg::OFS_COUNT, 32'h00000055); // Read-only: must not land
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    check_state();
    $display("test reset done");
    apb(1'b1, qc_pkg::OFS_CTRL, 32'h1);
    e_en = 1'b1;
    move(int'(rnd() % 4) + 1, 1'b0);
    check_state();
    v = e_cnt + 2 + (rnd() % 3);
    apb(1'b1, qc_pkg::OFS_UPPER, v);
    e_up = v;
    check_state();
    move(2, 1'b0);
    check_state();
    $display("test count up done");
    apb(1'b1, qc_pkg::OFS_CTRL, 32'h3);
    e_dir = 1'b1;
    v = -2 - (rnd() % 4);
    apb(1'b1, qc_pkg::OFS_LOWER, v);
    e_lo = v;
    move(8, 1'b0);
    check_state();
    apb(1'b1, qc_pkg::OFS_CTRL, 32'h1);
    e_dir = 1'b0;
    move(1, 1'b1);
    check_state();
    $display("test direction done");
    apb(1'b1, qc_pkg::OFS_CTRL, 32'h0);
    e_en = 1'b0;
    move(2, 1'b0);
    check_state();
    apb(1'b1, qc_pkg::OFS_CTRL, 32'h1);
    e_en = 1'b1;
    set_run(1'b0);
    move(1, 1'b0);
    check_state();
    apb(1'b1, qc_pkg::OFS_CMD, 32'h2);
    check_state();
    v = rnd();
    apb(1'b1, qc_pkg::OFS_PRESET, v);
    apb(1'b1, qc_pkg::OFS_CMD, 32'h1);
    e_cnt = v;
    check_state();
    set_run(1'b1);
    apb(1'b1, qc_pkg::OFS_CMD, 32'h3);
    e_cnt = 0;
    check_state();
    $display("test commands done");
    // Step off each end of the range, one direction at a time
    for (k = 0; k < 2; k++) begin
      v = k ? qc_pkg::COUNT_MIN + 1 : qc_pkg::COUNT_MAX - 1;
      apb(1'b1, qc_pkg::OFS_PRESET, v);
      apb(1'b1, qc_pkg::OFS_CMD, 32'h1);
      {e_cnt, e_ovf} = {v, 1'b0};
      move(1, k[0]);
      check_state();
    end
    apb(1'b1, qc_pkg::OFS_CMD, 32'h1);
    {e_cnt, e_ovf} = {v, 1'b0};
    check_state();
    $display("test overflow done");
    @(posedge pclk);
    retain_cfg <= 1'b1;
    move(3, 1'b0);
    set_run(1'b0);
    check_state();
    set_run(1'b1);
    do_reset();
    check_state();
    @(posedge pclk);
    retain_cfg <= 1'b0;
    do_reset();
    e_cnt = 0;
    check_state();
    $display("test retention done");
    tally_and_finish();
  end

  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    $display("Error at %0t: run too long", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
